// File: usb_host_ctrl_cfg.svh
// Offsets, field positions, reset values and timing figures of the host control block
`ifndef USB_HOST_CTRL_CFG_SVH
`define USB_HOST_CTRL_CFG_SVH

`define SYS_CLK_MHZ 10
`define BUS_RESET_TIME_US 10000
`define RESUME_TIME_US 20000
`define FRAME_TIME_US 1000

`define ADDR_W 12
`define OFS_HOST_GENERAL_CONTROL 12'h400
`define OFS_HOST_GLOBAL_IRQ_FLAGS 12'h404
`define OFS_HOST_IRQ_FLAG_CLEAR 12'h408
`define OFS_HOST_IRQ_FLAG_SET 12'h40C
`define OFS_HOST_IRQ_ENABLES 12'h410
`define OFS_HOST_IRQ_ENABLE_CLEAR 12'h414
`define OFS_HOST_IRQ_ENABLE_SET 12'h418

`define CTRL_SPEED_LSB 12
`define CTRL_RESUME_BIT 10
`define CTRL_RESET_BIT 9
`define CTRL_FRAME_START_GEN_ENABLE_BIT 8
`define CTRL_MASK 32'h0000_3700
`define CTRL_RESET_VALUE 32'h0000_0000

`define SPEED_NORMAL 2'h0
`define SPEED_FULL_ONLY 2'h3

`define FLAG_WAKEUP_BIT 6
`define FLAG_SOF_BIT 5
`define FLAG_UP_RESUME_BIT 4
`define FLAG_RESUME_DONE_BIT 3
`define FLAG_RESET_SENT_BIT 2
`define FLAG_DISCONNECT_BIT 1
`define FLAG_CONNECT_BIT 0
`define FLAG_EVENT_MASK 32'h0000_007F
`define FLAG_PIPE_LSB 8
`define FLAG_DMA_LSB 25
`define FLAG_FORCE_MASK 32'hFE00_007F
`define ENABLE_MASK 32'hFE00_FF7F
`define FLAGS_RESET_VALUE 32'h0000_0000

`endif

// File: usb_host_ctrl_pkg.sv
// Types shared by the host control block
package usb_host_ctrl_pkg;
   typedef enum logic [1:0] {
      LINE_IDLE,
      LINE_FRAMES,
      LINE_RESET,
      LINE_RESUME
   } line_state_e;
   typedef logic [31:0] word_t;
endpackage : usb_host_ctrl_pkg

// File: line_timer_if.sv
// Start, abort and completion signals of one line timer
`timescale 1ns/1ps
`default_nettype none
interface line_timer_if;
   logic start;
   logic abort;
   logic busy;
   logic done;
   modport owner (output start, output abort, input busy, input done);
   modport timer (input start, input abort, output busy, output done);
endinterface : line_timer_if
`default_nettype wire

// File: line_timer.sv
// Down counter that times one line activity
`timescale 1ns/1ps
`default_nettype none
module line_timer #(
   parameter int CYCLES = 16
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   line_timer_if.timer tmr
);
   logic [31:0] count_reg;
   logic [31:0] count_next;
   logic busy_reg;
   logic busy_next;
   logic done_reg;
   logic done_next;
   wire logic last_tick = busy_reg && (count_reg == 32'h0000_0001);

   initial
   begin
      if (CYCLES < 1)
      begin
         $error("line_timer needs at least one cycle");
      end
   end

   // Start reloads, abort wins and ends without completion
   assign busy_next = !tmr.abort && (tmr.start || (busy_reg && !last_tick));
   assign done_next = !tmr.abort && !tmr.start && last_tick;
   assign count_next = tmr.start ? 32'(CYCLES) : (busy_reg ? count_reg - 32'h0000_0001 : count_reg);
   assign tmr.busy = busy_reg;
   assign tmr.done = done_reg;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         count_reg <= 32'h0000_0000;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end
endmodule : line_timer
`default_nettype wire

// File: usb_host_bus_ctrl.sv
// Host general control and global interrupt flags of the USB host controller
//
// Function
// - Speed code 00: full speed, high after handshake
// - Code 11 stays full speed; 01/10 reserved
// - Writing resume one drives resume; zero ignored
// - Resume bit clears when done or reset
// - Reset bit drives bus reset, self-clears
// - Writing reset zero aborts a running reset
// - Frame enable emits frames or keep-alives
// - Reset request or upstream resume sets enable
// - Bits 31:25 mirror DMA channel interrupts
// - Bits 15:8 mirror pipe interrupts
// - Wake-up on suspend events or session request
// - Wake-up detection survives clock freeze
// - Frame flag set per frame, write clears
// - Upstream resume flag, cleared by software
// - Resume done flag, cleared by software
// - Reset sent flag, cleared by software
// - Disconnection flag, cleared by software
// - Connection flag, cleared by software
// - Clear register clears flags written one
// - Set register forces event and DMA flags written one
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "usb_host_ctrl_cfg.svh"
module usb_host_bus_ctrl
   import usb_host_ctrl_pkg::*;
#(
   parameter int RESET_CYCLES = `BUS_RESET_TIME_US * `SYS_CLK_MHZ,
   parameter int RESUME_CYCLES = `RESUME_TIME_US * `SYS_CLK_MHZ,
   parameter int FRAME_CYCLES = `FRAME_TIME_US * `SYS_CLK_MHZ,
   parameter int PIPES = 8,
   parameter int DMA_CHANNELS = 7
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [`ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic dev_connect_pin,
   input wire logic dev_disconnect_pin,
   input wire logic upstream_resume_pin,
   input wire logic session_request_pin,
   input wire logic hs_capable_pin,
   input wire logic low_speed_dev_pin,
   input wire logic bus_power_request,
   input wire logic clock_freeze_control,
   input wire logic [PIPES-1:0] pipe_irq_src,
   input wire logic [DMA_CHANNELS:1] dma_irq_src,
   output logic bus_reset_drive,
   output logic bus_resume_drive,
   output logic sof_token_strobe,
   output logic keepalive_strobe,
   output logic high_speed,
   output logic irq_out
);
   localparam int NPIN = 6;

   initial
   begin
      if (PIPES != 8 || DMA_CHANNELS != 7)
      begin
         $error("flag layout serves exactly 8 pipes and 7 DMA channels");
      end
   end

   // Pin synchroniser, two stages, then edge history
   logic [NPIN-1:0] pin_meta_reg;
   logic [NPIN-1:0] pin_sync_reg;
   logic [NPIN-1:0] pin_prev_reg;
   wire logic [NPIN-1:0] pin_raw = {low_speed_dev_pin, hs_capable_pin, session_request_pin,
                                    upstream_resume_pin, dev_disconnect_pin, dev_connect_pin};
   wire logic [NPIN-1:0] pin_rise = pin_sync_reg & ~pin_prev_reg;
   wire logic connect_ev = pin_rise[0];
   wire logic disconnect_ev = pin_rise[1];
   wire logic up_resume_ev = pin_rise[2];
   wire logic srp_ev = pin_rise[3];
   wire logic hs_capable = pin_sync_reg[4];
   wire logic low_speed_dev = pin_sync_reg[5];

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
         pin_prev_reg <= '0;
      end
      else
      begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // Register decode
   wire logic wr_ctrl = reg_wr && (reg_addr == `OFS_HOST_GENERAL_CONTROL);
   wire logic wr_clr = reg_wr && (reg_addr == `OFS_HOST_IRQ_FLAG_CLEAR);
   wire logic wr_set = reg_wr && (reg_addr == `OFS_HOST_IRQ_FLAG_SET);
   wire logic wr_en_clr = reg_wr && (reg_addr == `OFS_HOST_IRQ_ENABLE_CLEAR);
   wire logic wr_en_set = reg_wr && (reg_addr == `OFS_HOST_IRQ_ENABLE_SET);
   wire word_t clr_bits = wr_clr ? reg_wdata : 32'h0000_0000;
   wire word_t set_bits = wr_set ? (reg_wdata & `FLAG_FORCE_MASK) : 32'h0000_0000;

   // Control register fields
   logic [1:0] speed_reg;
   logic resume_reg;
   logic reset_reg;
   logic frame_start_gen_enable_reg;
   logic [1:0] speed_next;
   logic resume_next;
   logic reset_next;
   logic frame_start_gen_enable_next;

   wire logic reset_req = wr_ctrl && reg_wdata[`CTRL_RESET_BIT];
   wire logic reset_abort = wr_ctrl && !reg_wdata[`CTRL_RESET_BIT] && reset_reg;
   wire logic resume_req = wr_ctrl && reg_wdata[`CTRL_RESUME_BIT] && !reset_req;

   // Line timers
   line_timer_if reset_tmr ();
   line_timer_if resume_tmr ();
   line_timer_if frame_tmr ();

   line_timer #(.CYCLES(RESET_CYCLES)) u_reset_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tmr(reset_tmr)
   );
   line_timer #(.CYCLES(RESUME_CYCLES)) u_resume_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tmr(resume_tmr)
   );
   line_timer #(.CYCLES(FRAME_CYCLES)) u_frame_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tmr(frame_tmr)
   );

   // Line activity state machine
   line_state_e state_reg;
   line_state_e state_next;
   wire logic reset_done = (state_reg == LINE_RESET) && reset_tmr.done;
   wire logic resume_done = (state_reg == LINE_RESUME) && resume_tmr.done;

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         LINE_IDLE, LINE_FRAMES:
         begin
            if (reset_req)
            begin
               state_next = LINE_RESET;
            end
            else if (resume_req && !resume_reg)
            begin
               state_next = LINE_RESUME;
            end
            else if (frame_start_gen_enable_next)
            begin
               state_next = LINE_FRAMES;
            end
            else
            begin
               state_next = LINE_IDLE;
            end
         end
         LINE_RESET:
         begin
            if (reset_abort)
            begin
               state_next = frame_start_gen_enable_next ? LINE_FRAMES : LINE_IDLE;
            end
            else if (reset_tmr.done)
            begin
               state_next = frame_start_gen_enable_next ? LINE_FRAMES : LINE_IDLE;
            end
         end
         LINE_RESUME:
         begin
            if (reset_req)
            begin
               state_next = LINE_RESET;
            end
            else if (resume_tmr.done)
            begin
               state_next = frame_start_gen_enable_next ? LINE_FRAMES : LINE_IDLE;
            end
         end
      endcase
   end

   // Timer commands follow state entry and exit
   assign reset_tmr.start = reset_req;
   assign reset_tmr.abort = reset_abort;
   assign resume_tmr.start = (state_reg != LINE_RESUME) && (state_next == LINE_RESUME);
   assign resume_tmr.abort = (state_reg == LINE_RESUME) && reset_req;
   assign frame_tmr.start = (state_next == LINE_FRAMES) && !clock_freeze_control
                            && ((state_reg != LINE_FRAMES) || frame_tmr.done
                                || !frame_tmr.busy);
   assign frame_tmr.abort = (state_next != LINE_FRAMES) || clock_freeze_control;

   wire logic frame_tick = (state_reg == LINE_FRAMES) && frame_tmr.done;

   // Control register next values
   assign speed_next = wr_ctrl ? reg_wdata[`CTRL_SPEED_LSB +: 2] : speed_reg;
   assign resume_next = (resume_reg || resume_tmr.start) && !resume_done && !reset_req;
   assign reset_next = (reset_reg || reset_req) && !reset_done && !reset_abort;
   assign frame_start_gen_enable_next = reset_req || up_resume_ev
                      || (wr_ctrl ? reg_wdata[`CTRL_FRAME_START_GEN_ENABLE_BIT] : frame_start_gen_enable_reg);

   // Speed chosen at the end of each completed reset
   logic high_speed_next;
   assign high_speed_next = reset_req ? 1'b0
                          : (reset_done ? ((speed_reg == `SPEED_NORMAL) && hs_capable)
                          : high_speed);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state_reg <= LINE_IDLE;
         speed_reg <= 2'h0;
         resume_reg <= 1'b0;
         reset_reg <= 1'b0;
         frame_start_gen_enable_reg <= 1'b0;
         high_speed <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         speed_reg <= speed_next;
         resume_reg <= resume_next;
         reset_reg <= reset_next;
         frame_start_gen_enable_reg <= frame_start_gen_enable_next;
         high_speed <= high_speed_next;
      end
   end

   // Event flags, set wins over clear
   logic [6:0] event_reg;
   logic [6:0] event_next;
   logic [6:0] event_hw;
   wire logic wakeup_ev = (!frame_start_gen_enable_reg && (up_resume_ev || disconnect_ev))
                          || (!bus_power_request && srp_ev);

   always_comb
   begin
      event_hw = 7'h00;
      event_hw[`FLAG_WAKEUP_BIT] = wakeup_ev;
      event_hw[`FLAG_SOF_BIT] = frame_tick;
      event_hw[`FLAG_UP_RESUME_BIT] = up_resume_ev;
      event_hw[`FLAG_RESUME_DONE_BIT] = resume_done;
      event_hw[`FLAG_RESET_SENT_BIT] = reset_done;
      event_hw[`FLAG_DISCONNECT_BIT] = disconnect_ev;
      event_hw[`FLAG_CONNECT_BIT] = connect_ev;
   end

   assign event_next = (event_reg & ~clr_bits[6:0])
                       | event_hw | set_bits[6:0];

   // DMA flags follow their source, a forced bit holds until cleared
   logic [DMA_CHANNELS:1] dma_force_reg;
   logic [DMA_CHANNELS:1] dma_force_next;
   assign dma_force_next = (dma_force_reg & ~clr_bits[`FLAG_DMA_LSB +: DMA_CHANNELS])
                           | set_bits[`FLAG_DMA_LSB +: DMA_CHANNELS];
   wire logic [DMA_CHANNELS:1] dma_flag = dma_irq_src | dma_force_reg;
   wire logic [PIPES-1:0] pipe_flag = pipe_irq_src;

   wire word_t flags = {dma_flag, 9'h000, pipe_flag, 1'b0, event_reg};

   // Enables, set wins over clear
   word_t enable_reg;
   word_t enable_next;
   assign enable_next = ((enable_reg & ~(wr_en_clr ? reg_wdata : 32'h0000_0000))
                        | (wr_en_set ? reg_wdata : 32'h0000_0000)) & `ENABLE_MASK;

   wire logic irq_next = |(flags & enable_reg);

   // Line outputs
   wire logic reset_drive_next = (state_next == LINE_RESET);
   wire logic resume_drive_next = (state_next == LINE_RESUME);
   wire logic sof_next = frame_tick && !low_speed_dev;
   wire logic keepalive_next = frame_tick && low_speed_dev;

   // Read data
   wire word_t ctrl_view = {18'h00000, speed_reg, 1'b0, resume_reg, reset_reg, frame_start_gen_enable_reg, 8'h00};
   word_t read_mux;
   always_comb
   begin
      unique case (reg_addr)
         `OFS_HOST_GENERAL_CONTROL: read_mux = ctrl_view;
         `OFS_HOST_GLOBAL_IRQ_FLAGS: read_mux = flags;
         `OFS_HOST_IRQ_ENABLES: read_mux = enable_reg;
         default: read_mux = 32'h0000_0000;
      endcase
   end
   wire word_t rdata_next = reg_rd ? read_mux : 32'h0000_0000;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         event_reg <= 7'h00;
         dma_force_reg <= '0;
         enable_reg <= 32'h0000_0000;
         irq_out <= 1'b0;
         reg_rdata <= 32'h0000_0000;
      end
      else
      begin
         event_reg <= event_next;
         dma_force_reg <= dma_force_next;
         enable_reg <= enable_next;
         irq_out <= irq_next;
         reg_rdata <= rdata_next;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         bus_reset_drive <= 1'b0;
         bus_resume_drive <= 1'b0;
         sof_token_strobe <= 1'b0;
         keepalive_strobe <= 1'b0;
      end
      else
      begin
         bus_reset_drive <= reset_drive_next;
         bus_resume_drive <= resume_drive_next;
         sof_token_strobe <= sof_next;
         keepalive_strobe <= keepalive_next;
      end
   end
endmodule : usb_host_bus_ctrl
`default_nettype wire

// File: usb_host_bus_ctrl_monitor.sv
// Assertion checker for the host control block
`timescale 1ns/1ps
`default_nettype none
`include "usb_host_ctrl_cfg.svh"
module usb_host_bus_mon #(
   parameter int RESET_CYCLES = 20,
   parameter int RESUME_CYCLES = 30
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [`ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic bus_reset_drive,
   input wire logic bus_resume_drive,
   input wire logic sof_token_strobe,
   input wire logic keepalive_strobe,
   input wire logic high_speed
);
   localparam int RST_MAX = RESET_CYCLES + 3;
   localparam int RSM_MAX = RESUME_CYCLES + 3;
   wire logic ctl_wr;
   assign ctl_wr = reg_wr && (reg_addr == 12'h400);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   property p_rst_start;
      ctl_wr && reg_wdata[9] |=> bus_reset_drive;
   endproperty
   a_rst_start: assert property (p_rst_start) else $error("reset not driven");
   property p_rst_abort;
      ctl_wr && !reg_wdata[9] && bus_reset_drive |=> !bus_reset_drive;
   endproperty
   a_rst_abort: assert property (p_rst_abort) else $error("reset not aborted");
   property p_rst_ends;
      $rose(bus_reset_drive) |-> ##[1:RST_MAX] !bus_reset_drive;
   endproperty
   a_rst_ends: assert property (p_rst_ends) else $error("reset too long");
   property p_rsm_start;
      ctl_wr && reg_wdata[10] && !reg_wdata[9] && !bus_reset_drive |=> bus_resume_drive;
   endproperty
   a_rsm_start: assert property (p_rsm_start) else $error("resume not driven");
   property p_rsm_cut;
      ctl_wr && reg_wdata[9] |=> !bus_resume_drive;
   endproperty
   a_rsm_cut: assert property (p_rsm_cut) else $error("resume not cut");
   property p_rsm_ends;
      $rose(bus_resume_drive) |-> ##[1:RSM_MAX] !bus_resume_drive;
   endproperty
   a_rsm_ends: assert property (p_rsm_ends) else $error("resume too long");
   property p_frame_pulse;
      sof_token_strobe || keepalive_strobe |=> !sof_token_strobe && !keepalive_strobe;
   endproperty
   a_frame_pulse: assert property (p_frame_pulse) else $error("strobe too wide");
   property p_frame_excl;
      sof_token_strobe |-> !keepalive_strobe;
   endproperty
   a_frame_excl: assert property (p_frame_excl) else $error("both strobes");
   property p_hs_low;
      bus_reset_drive |-> !high_speed;
   endproperty
   a_hs_low: assert property (p_hs_low) else $error("high speed in reset");
   c_reset: cover property ($fell(bus_reset_drive));
   c_resume: cover property ($fell(bus_resume_drive));
   c_keep: cover property (keepalive_strobe);
endmodule : usb_host_bus_mon
bind usb_host_bus_ctrl usb_host_bus_mon #(
   .RESET_CYCLES(RESET_CYCLES),
   .RESUME_CYCLES(RESUME_CYCLES)
) u_mon (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .bus_reset_drive,
   .bus_resume_drive, .sof_token_strobe, .keepalive_strobe, .high_speed);
`default_nettype wire

// File: usb_peripheral_model.sv
// Downstream peripheral model driving attach, resume and speed lines
`timescale 1ns/1ps
`default_nettype none
module usb_peripheral_model (
   input wire logic sys_clk,
   input wire logic bus_reset_drive,
   output logic dev_connect_pin,
   output logic dev_disconnect_pin,
   output logic upstream_resume_pin,
   output logic session_request_pin,
   output logic hs_capable_pin,
   output logic low_speed_dev_pin
);
   logic hs_able = 1'h0;
   logic [3:0] ev = 4'h0;
   initial hs_capable_pin = 1'h0;
   initial low_speed_dev_pin = 1'h0;
   assign {session_request_pin, upstream_resume_pin, dev_disconnect_pin, dev_connect_pin} = ev;
   // Handshake answer during bus reset, lost on removal
   always @(posedge sys_clk)
      if (bus_reset_drive && hs_able)
         hs_capable_pin <= 1'h1;
      else if (ev[1])
         hs_capable_pin <= 1'h0;
   task automatic pulse(input int idx);
      @(posedge sys_clk);
      ev[idx] <= 1'h1;
      repeat (3) @(posedge sys_clk);
      ev[idx] <= 1'h0;
   endtask : pulse
   task automatic set_speed(input logic hs, input logic ls);
      @(posedge sys_clk);
      hs_able <= hs;
      low_speed_dev_pin <= ls;
   endtask : set_speed
endmodule : usb_peripheral_model
`default_nettype wire

// File: usb_host_bus_ctrl_tb_top.sv
// Self-checking bench for the host control block
`timescale 1ns/1ps
`default_nettype none
module usb_host_bus_ctrl_tb_top;
   logic sys_clk = 1'h0;
   logic rst_n;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr, reg_rd, pwr_req, freeze;
   logic [7:0] pipe_src;
   logic [7:1] dma_src;
   logic [31:0] reg_rdata;
   logic conn, disc, ursm, sreq, hs_cap, ls_dev, rst_drv, rsm_drv, sof_s, ka_s, hs, irq;
   int bad_count = 0, tests_run = 0, cycles = 0;
   always #50 sys_clk = ~sys_clk;
   usb_peripheral_model peer (.sys_clk, .bus_reset_drive(rst_drv), .dev_connect_pin(conn),
      .dev_disconnect_pin(disc), .upstream_resume_pin(ursm), .session_request_pin(sreq),
      .hs_capable_pin(hs_cap), .low_speed_dev_pin(ls_dev));
   usb_host_bus_ctrl #(.RESET_CYCLES(20), .RESUME_CYCLES(30), .FRAME_CYCLES(10)) dut (
      .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .dev_connect_pin(conn), .dev_disconnect_pin(disc), .upstream_resume_pin(ursm),
      .session_request_pin(sreq), .hs_capable_pin(hs_cap), .low_speed_dev_pin(ls_dev),
      .bus_power_request(pwr_req), .clock_freeze_control(freeze), .pipe_irq_src(pipe_src),
      .dma_irq_src(dma_src), .bus_reset_drive(rst_drv), .bus_resume_drive(rsm_drv),
      .sof_token_strobe(sof_s), .keepalive_strobe(ka_s), .high_speed(hs), .irq_out(irq));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
      input string what);
      @(posedge sys_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1;
      chk(what, e, reg_rdata & m);
   endtask : rd
   task automatic wait_lvl(ref logic s, input logic v);
      int i = 0;
      while (s !== v && i < 100)
      begin
         @(posedge sys_clk);
         #1;
         i++;
      end
   endtask : wait_lvl
   task automatic t_regs;
      rd(12'h400, '1, 32'h0, "control");
      rd(12'h404, '1, 32'h0, "flags");
      rd(12'h410, '1, 32'h0, "enables");
      wr(12'h404, 32'hFFFFFFFF);
      rd(12'h404, '1, 32'h0, "flags ro");
      rd(12'h408, '1, 32'h0, "clear reg");
      rd(12'h7FC, '1, 32'h0, "unmapped");
      $display("regs done");
   endtask : t_regs
   task automatic t_bus_reset(input logic [1:0] spd, input logic exp_hs);
      peer.set_speed(1'h1, 1'h0);
      wr(12'h400, {18'h0, spd, 12'h200});
      #1 chk("reset drive", 32'h1, {31'h0, rst_drv});
      rd(12'h400, 32'h300, 32'h300, "reset bits");
      wait_lvl(rst_drv, 1'h0);
      rd(12'h400, 32'h200, 32'h0, "reset bit");
      rd(12'h404, 32'h4, 32'h4, "reset flag");
      chk("high speed", {31'h0, exp_hs}, {31'h0, hs});
      wr(12'h408, 32'h4);
      rd(12'h404, 32'h4, 32'h0, "reset flag clr");
      $display("bus reset done");
   endtask : t_bus_reset
   task automatic t_abort;
      wr(12'h400, 32'h200);
      peer.pulse(1);
      wr(12'h400, 32'h100);
      #1 chk("abort drive", 32'h0, {31'h0, rst_drv});
      rd(12'h404, 32'h6, 32'h2, "abort flags");
      wr(12'h408, 32'h7F);
      $display("abort done");
   endtask : t_abort
   task automatic t_resume;
      wr(12'h400, 32'h500);
      #1 chk("resume drive", 32'h1, {31'h0, rsm_drv});
      wr(12'h400, 32'h100);
      #1 chk("resume zero", 32'h1, {31'h0, rsm_drv});
      wait_lvl(rsm_drv, 1'h0);
      rd(12'h400, 32'h400, 32'h0, "resume bit");
      rd(12'h404, 32'h8, 32'h8, "resume flag");
      wr(12'h408, 32'h8);
      rd(12'h404, 32'h8, 32'h0, "resume flag clr");
      wr(12'h400, 32'h500);
      wr(12'h400, 32'h300);
      #1 chk("resume cut", 32'h0, {31'h0, rsm_drv});
      rd(12'h400, 32'h400, 32'h0, "resume bit cut");
      wait_lvl(rst_drv, 1'h0);
      $display("resume done");
   endtask : t_resume
   task automatic t_frames;
      logic seen = 1'h0;
      wr(12'h408, 32'h20);
      wait_lvl(sof_s, 1'h1);
      chk("frame token", 32'h1, {31'h0, sof_s});
      rd(12'h404, 32'h20, 32'h20, "frame flag");
      wr(12'h408, 32'h20);
      rd(12'h404, 32'h20, 32'h0, "frame flag clr");
      peer.set_speed(1'h1, 1'h1);
      wait_lvl(ka_s, 1'h1);
      chk("keepalive", 32'h1, {31'h0, ka_s});
      rd(12'h404, 32'h20, 32'h20, "keepalive flag");
      wr(12'h400, 32'h0);
      repeat (30)
      begin
         @(posedge sys_clk);
         #1 seen |= sof_s | ka_s;
      end
      chk("idle bus", 32'h0, {31'h0, seen});
      peer.set_speed(1'h0, 1'h0);
      $display("frames done");
   endtask : t_frames
   task automatic t_wake;
      wr(12'h408, 32'h7F);
      @(posedge sys_clk);
      freeze <= 1'h1;
      peer.pulse(1);
      repeat (4) @(posedge sys_clk);
      rd(12'h404, 32'h7F, 32'h42, "disc wake");
      wr(12'h408, 32'h42);
      peer.pulse(2);
      repeat (4) @(posedge sys_clk);
      rd(12'h404, 32'h50, 32'h50, "resume wake");
      rd(12'h400, 32'h100, 32'h100, "frames back");
      wr(12'h400, 32'h0);
      wr(12'h408, 32'h6F);
      rd(12'h404, 32'h10, 32'h10, "resume flag kept");
      wr(12'h408, 32'h10);
      peer.pulse(3);
      repeat (4) @(posedge sys_clk);
      rd(12'h404, 32'h50, 32'h40, "session wake");
      wr(12'h408, 32'h40);
      pwr_req <= 1'h1;
      peer.pulse(3);
      repeat (4) @(posedge sys_clk);
      rd(12'h404, 32'h40, 32'h0, "powered session");
      peer.pulse(0);
      repeat (4) @(posedge sys_clk);
      rd(12'h404, 32'h1, 32'h1, "connect");
      wr(12'h408, 32'h7F);
      rd(12'h404, 32'h7F, 32'h0, "all clear");
      freeze <= 1'h0;
      pwr_req <= 1'h0;
      $display("wake done");
   endtask : t_wake
   task automatic t_irq;
      @(posedge sys_clk);
      pipe_src <= 8'h81;
      dma_src <= 7'h41;
      rd(12'h404, 32'hFE00FF00, 32'h82008100, "sources");
      wr(12'h418, 32'h100);
      repeat (3) @(posedge sys_clk);
      #1 chk("irq on", 32'h1, {31'h0, irq});
      rd(12'h410, '1, 32'h100, "enables");
      wr(12'h414, 32'h100);
      repeat (3) @(posedge sys_clk);
      #1 chk("irq masked", 32'h0, {31'h0, irq});
      pipe_src <= 8'h00;
      dma_src <= 7'h00;
      rd(12'h404, 32'hFE00FF00, 32'h0, "sources gone");
      wr(12'h40C, 32'hFE00007F);
      rd(12'h404, '1, 32'hFE00007F, "forced");
      wr(12'h408, 32'hFE000055);
      rd(12'h404, '1, 32'h2A, "partly cleared");
      wr(12'h408, 32'h7F);
      $display("irq done");
   endtask : t_irq
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         $display("timeout");
         final_report;
      end
   end
   initial
   begin
      rst_n <= 1'h0;
      reg_addr <= 12'h000;
      reg_wdata <= 32'h0000_0000;
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      pwr_req <= 1'h0;
      freeze <= 1'h0;
      pipe_src <= 8'h00;
      dma_src <= 7'h00;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'h1;
      t_regs;
      t_bus_reset(2'h0, 1'h1);
      t_bus_reset(2'h3, 1'h0);
      t_abort;
      t_resume;
      t_frames;
      t_wake;
      t_irq;
      final_report;
   end
endmodule : usb_host_bus_ctrl_tb_top
`default_nettype wire
